// ### src/sdm_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdm_cfg.svh"
module sdm_top import sdm_pkg::*; (
  input  wire logic         ref_clk_i,    // system clock
  input  wire logic         rst_i,        // sync reset
  input  wire logic         ce_i,         // clock enable
  input  wire logic         hsel_i,       // ahb select
  input  wire logic [31:0]  haddr_i,      // ahb address
  input  wire logic [1:0]   htrans_i,     // ahb transfer type
  input  wire logic         hwrite_i,     // ahb write
  input  wire logic [2:0]   hsize_i,      // ahb size
  input  wire logic [31:0]  hwdata_i,     // ahb write data
  input  wire logic         hready_i,     // ahb bus ready
  output logic      [31:0]  hrdata_o,     // ahb read data
  output logic              hreadyout_o,  // ahb slave ready
  output logic              hresp_o,      // ahb response
  input  wire sdm_key_src_t key_src_i,    // keying sources
  input  wire sdm_car_src_t car_src_i,    // carrier sources
  output logic              mod_pin_o     // modulated pin
);

  // ---------------------------------------------
  // register state
  // ---------------------------------------------
  logic       modulator_enable_bit; // module on
  logic       output_invert;        // pin polarity
  logic       software_keying_bit;  // firmware key
  logic [3:0] keying_source_select; // key mux code
  logic       high_carrier_invert;  // high polarity
  logic       high_carrier_sync;    // high sync
  logic [3:0] high_carrier_select;  // high mux code
  logic       low_carrier_invert;   // low polarity
  logic       low_carrier_sync;     // low sync
  logic [3:0] low_carrier_select;   // low mux code

  // ---------------------------------------------
  // bus side signals
  // ---------------------------------------------
  sdm_aphase_t aph;      // pending data phase
  logic        take;     // address phase taken
  logic        wr_ctrl;  // write control reg
  logic        wr_key;   // write keying reg
  logic        wr_hcar;  // write high reg
  logic        wr_lcar;  // write low reg
  logic [7:0]  rd_byte;  // read mux result
  logic [7:0]  wbyte;    // low write byte

  // ---------------------------------------------
  // datapath signals
  // ---------------------------------------------
  logic       key_sel;   // selected keying
  logic       keying_signal; // effective keying
  logic       h_sel;     // selected high source
  logic       l_sel;     // selected low source
  logic       carrier_high_signal; // gated high
  logic       carrier_low_signal;  // gated low
  logic [1:0] act;       // active carriers
  logic       mix;       // mixed value
  logic       next_pin;  // next pin level

  // ---------------------------------------------
  // ahb-lite slave handshake
  // ---------------------------------------------
  // no wait states; frozen while clock enable low
  assign hreadyout_o = ce_i;
  // always okay
  assign hresp_o = 1'b0;
  // nonseq or seq taken when bus ready
  assign take = hsel_i & htrans_i[1] & hready_i & ce_i;
  assign wbyte = hwdata_i[7:0];

  // capture address phase for the data phase
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      aph <= '0;
    end else if (ce_i) begin
      aph.valid <= take;
      aph.wr    <= hwrite_i;
      aph.addr  <= haddr_i[7:0];
    end
  end

  // data phase write strobes
  assign wr_ctrl = aph.valid & aph.wr & (aph.addr == `SDM_CTRL_OFS);
  assign wr_key  = aph.valid & aph.wr & (aph.addr == `SDM_KEYSRC_OFS);
  assign wr_hcar = aph.valid & aph.wr & (aph.addr == `SDM_HCAR_OFS);
  assign wr_lcar = aph.valid & aph.wr & (aph.addr == `SDM_LCAR_OFS);

  // ---------------------------------------------
  // read mux
  // ---------------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    case (haddr_i[7:0])
      `SDM_CTRL_OFS: begin
        rd_byte[`SDM_CTRL_EN_BIT]   = modulator_enable_bit;
        rd_byte[`SDM_CTRL_OINV_BIT] = output_invert;
        rd_byte[`SDM_CTRL_STAT_BIT] = mod_pin_o;
        rd_byte[`SDM_CTRL_SW_BIT]   = software_keying_bit;
      end
      `SDM_KEYSRC_OFS: begin
        rd_byte[`SDM_SEL_MSB:`SDM_SEL_LSB] = keying_source_select;
      end
      `SDM_HCAR_OFS: begin
        rd_byte[`SDM_CAR_INV_BIT]  = high_carrier_invert;
        rd_byte[`SDM_CAR_SYNC_BIT] = high_carrier_sync;
        rd_byte[`SDM_SEL_MSB:`SDM_SEL_LSB] = high_carrier_select;
      end
      `SDM_LCAR_OFS: begin
        rd_byte[`SDM_CAR_INV_BIT]  = low_carrier_invert;
        rd_byte[`SDM_CAR_SYNC_BIT] = low_carrier_sync;
        rd_byte[`SDM_SEL_MSB:`SDM_SEL_LSB] = low_carrier_select;
      end
      // unmapped reads as zero
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // read data registered at the address phase
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (ce_i && take && !hwrite_i) begin
      hrdata_o <= {24'h00_0000, rd_byte};
    end
  end

  // ---------------------------------------------
  // control register
  // ---------------------------------------------
  // reset clears enable, polarity, software bit
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      modulator_enable_bit <= `SDM_BIT_RST;
      output_invert        <= `SDM_BIT_RST;
      software_keying_bit  <= `SDM_BIT_RST;
    end else if (ce_i && wr_ctrl) begin
      modulator_enable_bit <= wbyte[`SDM_CTRL_EN_BIT];
      output_invert        <= wbyte[`SDM_CTRL_OINV_BIT];
      software_keying_bit  <= wbyte[`SDM_CTRL_SW_BIT];
    end
  end

  // ---------------------------------------------
  // source select registers
  // ---------------------------------------------
  // only bus writes and reset change them, never enable
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      keying_source_select <= `SDM_SEL_RST;
    end else if (ce_i && wr_key) begin
      keying_source_select <= wbyte[`SDM_SEL_MSB:`SDM_SEL_LSB];
    end
  end

  // high carrier selection, sync, polarity
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      high_carrier_invert <= `SDM_BIT_RST;
      high_carrier_sync   <= `SDM_BIT_RST;
      high_carrier_select <= `SDM_SEL_RST;
    end else if (ce_i && wr_hcar) begin
      high_carrier_invert <= wbyte[`SDM_CAR_INV_BIT];
      high_carrier_sync   <= wbyte[`SDM_CAR_SYNC_BIT];
      high_carrier_select <= wbyte[`SDM_SEL_MSB:`SDM_SEL_LSB];
    end
  end

  // low carrier selection, sync, polarity
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      low_carrier_invert <= `SDM_BIT_RST;
      low_carrier_sync   <= `SDM_BIT_RST;
      low_carrier_select <= `SDM_SEL_RST;
    end else if (ce_i && wr_lcar) begin
      low_carrier_invert <= wbyte[`SDM_CAR_INV_BIT];
      low_carrier_sync   <= wbyte[`SDM_CAR_SYNC_BIT];
      low_carrier_select <= wbyte[`SDM_SEL_MSB:`SDM_SEL_LSB];
    end
  end

  // ---------------------------------------------
  // source multiplexers
  // ---------------------------------------------
  // keying: code zero is the software bit
  sdm_src_mux #(.N(12)) u_key_mux (
    .src_i  (key_src_i),
    .sel_i  (keying_source_select),
    .base_i (software_keying_bit),
    .sel_o  (key_sel)
  );

  // high carrier: code zero is ground
  sdm_src_mux #(.N(12)) u_hcar_mux (
    .src_i  (car_src_i),
    .sel_i  (high_carrier_select),
    .base_i (1'b0),
    .sel_o  (h_sel)
  );

  // low carrier: same source set
  sdm_src_mux #(.N(12)) u_lcar_mux (
    .src_i  (car_src_i),
    .sel_i  (low_carrier_select),
    .base_i (1'b0),
    .sel_o  (l_sel)
  );

  // ---------------------------------------------
  // enable gating and polarity
  // ---------------------------------------------
  // disabled: software bit keys, carriers grounded
  assign keying_signal = modulator_enable_bit ? key_sel : software_keying_bit;
  assign carrier_high_signal =
    modulator_enable_bit & (h_sel ^ high_carrier_invert);
  assign carrier_low_signal =
    modulator_enable_bit & (l_sel ^ low_carrier_invert);

  // ---------------------------------------------
  // carrier synchronisation
  // ---------------------------------------------
  // samples carriers on ref_clk_i, so carrier falls are seen only at its edges
  sdm_carrier_sync u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .want_i    ({~keying_signal, keying_signal}),
    .car_i     ({carrier_low_signal, carrier_high_signal}),
    .sync_i    ({low_carrier_sync, high_carrier_sync}),
    .act_o     (act)
  );

  // ---------------------------------------------
  // mixing and output
  // ---------------------------------------------
  // each active carrier passes; both during handover
  assign mix = (act[0] & carrier_high_signal)
             | (act[1] & carrier_low_signal);

  // disabled pin low, else mix through polarity
  always_comb begin
    next_pin = 1'b0;
    if (modulator_enable_bit) begin
      next_pin = mix ^ output_invert;
    end
  end

  // pin driven from a flip-flop
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mod_pin_o <= 1'b0;
    end else if (ce_i) begin
      mod_pin_o <= next_pin;
    end
  end

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence ctrl_write_s;
    ce_i && wr_ctrl;
  endsequence

  en_write_a: assert property (
    ctrl_write_s |=> modulator_enable_bit == $past(wbyte[`SDM_CTRL_EN_BIT]))
    else $error("enable bit not written");

  off_pin_low_a: assert property (
    (ce_i && !modulator_enable_bit) |=> !mod_pin_o)
    else $error("pin not low while disabled");

  idle_level_a: assert property (
    (ce_i && modulator_enable_bit && !mix) |=> mod_pin_o == $past(output_invert))
    else $error("pin idle level wrong");

  out_polarity_a: assert property (
    (ce_i && modulator_enable_bit) |=> mod_pin_o == ($past(mix) ^ $past(output_invert)))
    else $error("pin polarity wrong");

  vss_forced_a: assert property (
    !modulator_enable_bit |-> !carrier_high_signal && !carrier_low_signal)
    else $error("carrier live while disabled");

  sw_keying_a: assert property (
    !modulator_enable_bit |-> keying_signal == software_keying_bit)
    else $error("keying not from software bit");

  sel_kept_a: assert property (
    (ce_i && $fell(modulator_enable_bit) && !wr_key && !$past(rst_i))
      |-> keying_source_select == $past(keying_source_select))
    else $error("selection lost on disable");

  status_read_a: assert property (
    (ce_i && take && !hwrite_i && haddr_i[7:0] == `SDM_CTRL_OFS)
      |=> hrdata_o[`SDM_CTRL_STAT_BIT] == $past(mod_pin_o))
    else $error("status bit not output value");

  reset_clear_a: assert property (
    @(posedge ref_clk_i) disable iff (1'b0)
      rst_i |=> !modulator_enable_bit && !mod_pin_o && keying_source_select == 4'h0)
    else $error("reset did not clear");

  // ---------------------------------------------
  // datapath checks
  // ---------------------------------------------
  hcar_write_a: assert property (
    (ce_i && wr_hcar) |=> high_carrier_select == $past(wbyte[`SDM_SEL_MSB:`SDM_SEL_LSB]))
    else $error("high carrier select not written");

  lcar_write_a: assert property (
    (ce_i && wr_lcar) |=> low_carrier_select == $past(wbyte[`SDM_SEL_MSB:`SDM_SEL_LSB]))
    else $error("low carrier select not written");

  key_write_a: assert property (
    (ce_i && wr_key) |=> keying_source_select == $past(wbyte[`SDM_SEL_MSB:`SDM_SEL_LSB]))
    else $error("keying select not written");

  sw_source_a: assert property (
    (modulator_enable_bit && keying_source_select == `SDM_BASE_CODE)
      |-> keying_signal == software_keying_bit)
    else $error("software bit not the keying source");

  ground_code_a: assert property (
    (high_carrier_select == `SDM_BASE_CODE || high_carrier_select > 4'hC)
      |-> h_sel == 1'b0)
    else $error("unused high code not ground");

  car_polarity_a: assert property (
    (modulator_enable_bit && h_sel == 1'b0) |-> carrier_high_signal == high_carrier_invert)
    else $error("high carrier polarity wrong");

  mix_gate_a: assert property (
    (act == 2'b01) |-> mix == carrier_high_signal)
    else $error("mix not gated by high carrier");

endmodule // sdm_top
`default_nettype wire

// ### src/sdm_cfg.svh
// Functional notes
// - enable bit starts mixing selected sources
// - disabled: both carriers forced to ground
// - disabled: keying taken from software bit
// - disable keeps stored source selections
// - output disabled holds pin low
// - four-bit keying source select field
// - four-bit high carrier select field
// - four-bit low carrier select, same set
// - output is keying gated active carrier
// - leaving synced carrier: hold until fall
// - returning: wait synced carrier falling edge
// - separate sync enables per carrier
// - separate polarity invert per carrier
// - software keying bit selectable as source
// - output invert bit inverts pin
// - invert set idles high, clear low
// - read-only status shows current output
// - keeps working whenever sources keep running; here only while ref_clk_i runs and ce_i is high
// - reset disables, registers to defaults
`ifndef SDM_CFG_SVH
`define SDM_CFG_SVH

// ---------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------
`define SDM_CTRL_OFS     8'h00
`define SDM_KEYSRC_OFS   8'h04
`define SDM_HCAR_OFS     8'h08
`define SDM_LCAR_OFS     8'h0C

// ---------------------------------------------
// field positions
// ---------------------------------------------
`define SDM_CTRL_EN_BIT   7
`define SDM_CTRL_OINV_BIT 4
`define SDM_CTRL_STAT_BIT 3
`define SDM_CTRL_SW_BIT   0
`define SDM_CAR_INV_BIT   7
`define SDM_CAR_SYNC_BIT  6
`define SDM_SEL_MSB       3
`define SDM_SEL_LSB       0

// ---------------------------------------------
// reset values and select codes
// ---------------------------------------------
`define SDM_BIT_RST      1'b0
`define SDM_SEL_RST      4'h0
`define SDM_BASE_CODE    4'h0

`endif

// ### src/sdm_pkg.sv
// ---------------------------------------------
// shared types of the signal modulator
// ---------------------------------------------
package sdm_pkg;

  // keying sources, bit n answers select code n+1
  typedef struct packed {
    logic clc2;
    logic clc1;
    logic nco;
    logic keying_input_pin;
    logic uart_tx;
    logic cmp2;
    logic cmp1;
    logic spi_sdo;
    logic pwm6;
    logic pwm5;
    logic ccp2;
    logic ccp1;
  } sdm_key_src_t;

  // carrier sources, bit n answers select code n+1
  typedef struct packed {
    logic carrier_input_pin_b;
    logic carrier_input_pin_a;
    logic reference_clock_output;
    logic clc2;
    logic clc1;
    logic internal_fast_oscillator;
    logic sys_clk;
    logic nco;
    logic pwm6;
    logic pwm5;
    logic ccp2;
    logic ccp1;
  } sdm_car_src_t;

  // captured ahb address phase
  typedef struct packed {
    logic       valid;
    logic       wr;
    logic [7:0] addr;
  } sdm_aphase_t;

  // per-carrier sync state
  typedef enum logic [1:0] {
    SDM_IDLE   = 2'b01,
    SDM_ACTIVE = 2'b10
  } sdm_sync_st_t;

endpackage

// ### src/sdm_src_mux.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdm_cfg.svh"
module sdm_src_mux import sdm_pkg::*; #(
  parameter int N = 12
) (
  input  wire logic [N-1:0] src_i,   // source bits
  input  wire logic [3:0]   sel_i,   // select code
  input  wire logic         base_i,  // value of code zero
  output logic              sel_o    // chosen source
);
  // ---------------------------------------------
  // code zero is base, 1..N sources, rest ground
  // ---------------------------------------------
  always_comb begin
    sel_o = 1'b0;
    if (sel_i == `SDM_BASE_CODE) begin
      sel_o = base_i;
    end else if (int'(sel_i) <= N) begin
      sel_o = src_i[int'(sel_i) - 1];
    end
  end
endmodule // sdm_src_mux
`default_nettype wire

// ### src/sdm_carrier_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sdm_carrier_sync import sdm_pkg::*; (
  input  wire logic       ref_clk_i, // system clock
  input  wire logic       rst_i,     // sync reset
  input  wire logic       ce_i,      // clock enable
  input  wire logic [1:0] want_i,    // keying asks for carrier
  input  wire logic [1:0] car_i,     // carrier levels
  input  wire logic [1:0] sync_i,    // sync enables
  output logic      [1:0] act_o      // carrier active
);
  // ---------------------------------------------
  // index 0 high carrier, index 1 low carrier
  // ---------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_car
    logic         prev; // last carrier sample
    sdm_sync_st_t st;   // latched activity
    logic         fall; // carrier fell
    assign fall = prev & ~car_i[g];
    // sample carrier for edge compare
    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        prev <= 1'b0;
      end else if (ce_i) begin
        prev <= car_i[g];
      end
    end
    // activity changes only at carrier falls
    always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
        st <= SDM_IDLE;
      end else if (ce_i && fall) begin
        st <= want_i[g] ? SDM_ACTIVE : SDM_IDLE;
      end
    end
    // unsynced follows keying at once
    assign act_o[g] = sync_i[g] ? (st == SDM_ACTIVE) : want_i[g];

    sequence no_fall_s;
      !(prev && !car_i[g]);
    endsequence
    property hold_p;
      @(posedge ref_clk_i) disable iff (rst_i)
        (ce_i && sync_i[g] && st == SDM_ACTIVE) ##0 no_fall_s
        |=> st == SDM_ACTIVE;
    endproperty
    sync_hold_a: assert property (hold_p)
      else $error("synced carrier dropped before fall");
    unsync_now_a: assert property (
      @(posedge ref_clk_i) disable iff (rst_i)
        !sync_i[g] |-> act_o[g] == want_i[g])
      else $error("unsynced carrier not immediate");
  end
endmodule // sdm_carrier_sync
`default_nettype wire

// ### testbench/sdm_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdm_src_model import sdm_pkg::*; (
  input  wire logic        clk_i,     // system clock
  input  wire logic        rst_i,     // sync reset
  input  wire logic        wave_en_i, // square wave on carrier pin a
  input  wire logic [11:0] key_lvl_i, // keying source levels
  input  wire logic [11:0] car_lvl_i, // carrier source levels
  output sdm_key_src_t     key_src_o, // to keying mux
  output sdm_car_src_t     car_src_o  // to carrier muxes
);
  // ---------------------------------------------
  // square carrier, period of 16 clocks
  // ---------------------------------------------
  logic [3:0] div; // wave divider

  // free running, so the carrier never stalls between uses
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div <= 4'h0;
    end else begin
      div <= div + 4'h1;
    end
  end

  // levels as given, pin a replaced by the wave when asked
  always_comb begin
    key_src_o = sdm_key_src_t'(key_lvl_i);
    car_src_o = sdm_car_src_t'(car_lvl_i);
    if (wave_en_i) begin
      car_src_o.carrier_input_pin_a = div[3];
    end
  end
endmodule // sdm_src_model
`default_nettype wire

// ### testbench/test_carrier_data_modulator.sv
`timescale 1ns/1ps
`default_nettype none
`include "sdm_cfg.svh"
module test_carrier_data_modulator import sdm_pkg::*;;
  // ---------------------------------------------
  // bench signals
  // ---------------------------------------------
  logic         ref_clk = 1'b0;  // 10 MHz
  logic         rst     = 1'b1;  // sync reset
  logic         hsel    = 1'b0;  // bus select
  logic [31:0]  haddr   = 32'h0; // bus address
  logic [1:0]   htrans  = 2'h0;  // bus transfer
  logic         hwrite  = 1'b0;  // bus write
  logic [31:0]  hwdata  = 32'h0; // bus write data
  logic [31:0]  hrdata;          // bus read data
  logic         hready;          // slave ready
  logic         hresp;           // slave response
  logic         wave_en = 1'b0;  // carrier wave on
  logic [11:0]  key_lvl = 12'h0; // keying levels
  logic [11:0]  car_lvl = 12'h0; // carrier levels
  sdm_key_src_t key_src;         // keying sources
  sdm_car_src_t car_src;         // carrier sources
  logic         mod_pin;         // modulated pin
  int           bad_count = 0;   // mismatches
  int           tests_run = 0;   // comparisons
  wire          car_wave = car_src.carrier_input_pin_a;
  localparam logic [31:0] EN = 32'h1 << `SDM_CTRL_EN_BIT;
  localparam logic [31:0] OI = 32'h1 << `SDM_CTRL_OINV_BIT;
  localparam logic [31:0] ST = 32'h1 << `SDM_CTRL_STAT_BIT;
  localparam logic [31:0] SW = 32'h1 << `SDM_CTRL_SW_BIT;
  localparam logic [31:0] INV = 32'h1 << `SDM_CAR_INV_BIT;
  localparam logic [31:0] SYN = 32'h1 << `SDM_CAR_SYNC_BIT;

  always #50 ref_clk = ~ref_clk;

  sdm_src_model PARTNER (.clk_i(ref_clk), .rst_i(rst), .wave_en_i(wave_en),
    .key_lvl_i(key_lvl), .car_lvl_i(car_lvl), .key_src_o(key_src), .car_src_o(car_src));

  sdm_top DUT (.ref_clk_i(ref_clk), .rst_i(rst), .ce_i(1'b1), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .key_src_i(key_src), .car_src_i(car_src), .mod_pin_o(mod_pin));

  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one single transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(x, exp);
  endtask

  // pin settles one cycle after the mix changes
  task automatic pin_chk(input logic exp);
    repeat (3) @(posedge ref_clk);
    #1;
    check({31'h0, mod_pin}, {31'h0, exp});
  endtask

  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_reset;
    rd_chk(`SDM_CTRL_OFS, 32'h0);
    rd_chk(`SDM_KEYSRC_OFS, 32'h0);
    rd_chk(`SDM_HCAR_OFS, 32'h0);
    rd_chk(`SDM_LCAR_OFS, 32'h0);
    check({31'h0, hresp}, 32'h0);
    wr(8'h10, 32'hFF);
    rd_chk(8'h10, 32'h0);
    wr(`SDM_CTRL_OFS, ST);
    rd_chk(`SDM_CTRL_OFS, 32'h0);
    $display("done: reset values");
  endtask

  // every select code of one field; hit codes pass their one source
  task automatic t_codes(input logic [7:0] a, input logic car, input logic [31:0] ctl);
    logic hit;
    logic [11:0] lv;
    wr(`SDM_CTRL_OFS, ctl);
    for (int c = 0; c < 16; c++) begin
      hit = (c >= 1) && (c <= 12);
      lv = hit ? (12'h001 << (c - 1)) : 12'hFFF;
      wr(a, c);
      if (car) car_lvl <= lv;
      else key_lvl <= lv;
      pin_chk(hit);
      if (car) begin
        wr(a, INV | c);
        pin_chk(!hit);
      end else begin
        @(posedge ref_clk);
        key_lvl <= hit ? ~lv : 12'h000;
        pin_chk(1'b0);
      end
    end
    $display("done: select codes at %h", a);
  endtask

  task automatic t_enable;
    wr(`SDM_KEYSRC_OFS, 32'h1);
    wr(`SDM_HCAR_OFS, INV);
    wr(`SDM_LCAR_OFS, 32'h0);
    key_lvl <= 12'h001;
    wr(`SDM_CTRL_OFS, EN);  // set up before enabling
    pin_chk(1'b1);
    rd_chk(`SDM_CTRL_OFS, EN | ST);
    wr(`SDM_CTRL_OFS, EN | OI);
    pin_chk(1'b0);
    @(posedge ref_clk);
    key_lvl <= 12'h000;
    pin_chk(1'b1);
    wr(`SDM_CTRL_OFS, OI);
    pin_chk(1'b0);
    wr(`SDM_CTRL_OFS, SW);
    key_lvl <= 12'h001;
    pin_chk(1'b0);
    rd_chk(`SDM_KEYSRC_OFS, 32'h1);
    rd_chk(`SDM_HCAR_OFS, INV);
    key_lvl <= 12'h000;
    wr(`SDM_CTRL_OFS, EN | SW);
    pin_chk(1'b0);
    @(posedge ref_clk);
    key_lvl <= 12'h001;
    pin_chk(1'b1);
    $display("done: enable and polarity");
  endtask

  // keying change launched just after the wave rises
  task automatic key_at_rise(input logic v, input logic exp);
    @(posedge car_wave);
    wr(`SDM_CTRL_OFS, EN | (v ? SW : 32'h0));
    pin_chk(exp);
  endtask

  task automatic t_sync;
    @(posedge ref_clk);
    wave_en <= 1'b1;
    wr(`SDM_KEYSRC_OFS, 32'h0);
    wr(`SDM_LCAR_OFS, 32'h0);
    wr(`SDM_CTRL_OFS, EN);
    wr(`SDM_HCAR_OFS, 32'hB);
    key_at_rise(1'b1, 1'b1);
    key_at_rise(1'b0, 1'b0);
    wr(`SDM_HCAR_OFS, SYN | 32'hB);
    key_at_rise(1'b1, 1'b0);
    repeat (11) @(posedge ref_clk);
    pin_chk(1'b1);
    key_at_rise(1'b0, 1'b1);
    repeat (11) @(posedge ref_clk);
    pin_chk(1'b0);
    // low carrier synced, high grounded
    wr(`SDM_HCAR_OFS, 32'h0);
    wr(`SDM_LCAR_OFS, SYN | 32'hB);
    repeat (16) @(posedge ref_clk);
    key_at_rise(1'b1, 1'b1);
    repeat (11) @(posedge ref_clk);
    pin_chk(1'b0);
    key_at_rise(1'b0, 1'b0);
    repeat (11) @(posedge ref_clk);
    pin_chk(1'b1);
    @(posedge ref_clk);
    wave_en <= 1'b0;
    $display("done: carrier sync");
  endtask

  task automatic t_midreset;
    wr(`SDM_HCAR_OFS, INV);
    wr(`SDM_CTRL_OFS, EN | SW);
    pin_chk(1'b1);
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    check({31'h0, mod_pin}, 32'h0);
    rd_chk(`SDM_CTRL_OFS, 32'h0);
    rd_chk(`SDM_HCAR_OFS, 32'h0);
    $display("done: reset in mid-run");
  endtask

  // ---------------------------------------------
  // verdict and run control
  // ---------------------------------------------
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    wr(`SDM_HCAR_OFS, INV);
    t_codes(`SDM_KEYSRC_OFS, 1'b0, EN);
    wr(`SDM_KEYSRC_OFS, 32'h0);
    t_codes(`SDM_HCAR_OFS, 1'b1, EN | SW);
    t_codes(`SDM_LCAR_OFS, 1'b1, EN);
    t_enable();
    t_sync();
    t_midreset();
    print_verdict();
  end

  // watchdog, well beyond the under one thousand cycles the run needs
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    print_verdict();
  end
endmodule // test_carrier_data_modulator
`default_nettype wire
